/* bench/ht_link_props.sv */
// Concurrent checks on the two-wire link between host and sensor.
module ht_link_props (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic h_sda_o,
	input wire logic h_sda_oe,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	input wire logic scl_i,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic bus_q;
	logic bus_d;
	logic sda_q;
	logic scl_q;

	// ----------------------------------------
	// Bus busy tracking
	// ----------------------------------------
	// Busy from a start until the next stop, both seen with the clock line high.
	assign bus_d = (scl_i && scl_q && sda_q && !sda_i) ? 1'b1 :
		(scl_i && scl_q && !sda_q && sda_i) ? 1'b0 : bus_q;

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			bus_q <= 1'b0;
			sda_q <= 1'b1;
			scl_q <= 1'b1;
		end else begin
			bus_q <= bus_d;
			sda_q <= sda_i;
			scl_q <= scl_i;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	open_drain_a: assert property (!scl_o && !h_sda_o && !d_sda_o)
		else $error("a line was driven high");
	start_by_host_a: assert property ($fell(sda_i) && scl_i && $past(scl_i) |-> h_sda_oe)
		else $error("start not made by the host");
	stop_by_host_a: assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> $past(h_sda_oe))
		else $error("stop not made by the host");
	dev_change_low_a: assert property ($changed(d_sda_oe) |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2))
		else $error("sensor changed data near a clock edge");
	shared_low_a: assert property (d_sda_oe && h_sda_oe |-> !scl_i)
		else $error("both ends drove data with clock high");
	start_then_clock_a: assert property ($rose(h_sda_oe) && scl_i |-> ##[1:300] !scl_i)
		else $error("no clock after start");
	stop_then_idle_a: assert property ($fell(h_sda_oe) && scl_i |-> (scl_i && sda_i) [*8])
		else $error("bus not idle after stop");
	scl_high_min_a: assert property ($rose(scl_i) |-> scl_i [*8])
		else $error("clock high phase too short");
	dev_quiet_idle_a: assert property (!bus_q |-> !d_sda_oe)
		else $error("sensor drove data on an idle bus");

	cover property ($rose(d_sda_oe));
	cover property ($fell(h_sda_oe) && scl_i);
	cover property (bus_q && d_sda_oe && scl_i);
endmodule : ht_link_props

/* bench/humidity_temp_i2c_readout_bench.sv */
// Self-checking bench joining the host and sensor ends across the link.
module humidity_temp_i2c_readout_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic [19:0] hum = 20'h12345;
	logic [19:0] tmp = 20'h6789A;
	logic factory_cal = 1'b1;
	logic want_crc = 1'b1;
	logic i_ref_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_measure = 1'b0;
	logic i_data_ready = 1'b0;
	logic o_ready, o_busy, o_calibrated, o_conv_start, o_idle, o_cal_ok, o_error, o_crc_ok;
	logic o_result_valid, o_data_valid;
	logic [13:0] o_rh_centi;
	logic signed [15:0] o_temp_centi;
	logic [7:0] o_data;
	logic [7:0] got_q [$];
	int err_count = 0;
	int samples_checked = 0;
	int starts = 0;
	logic busy_seen = 1'b0;

	always #5 i_ref_clk = ~i_ref_clk;

	ht_link_if ht_link_if_i ();

	// The sensor converts longer than the host waits, so the first status poll sees busy.
	ht_sensor_dev #(.PWR_CYCLES(1000), .CONV_CYCLES(4000)) ht_sensor_dev_i (.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n), .link(ht_link_if_i), .i_humidity_raw(hum), .i_temperature_raw(tmp),
		.i_factory_cal(factory_cal), .o_ready(o_ready), .o_busy(o_busy), .o_calibrated(o_calibrated),
		.o_conv_start(o_conv_start));

	ht_host #(.PWR_CYCLES(2000), .GAP_CYCLES(100), .CONV_CYCLES(2000), .POLL_CYCLES(500),
		.QUARTER_CYCLES(25)) ht_host_i (
		.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .link(ht_link_if_i), .i_measure(i_measure),
		.i_want_crc(want_crc), .o_idle(o_idle), .o_cal_ok(o_cal_ok), .o_error(o_error), .o_crc_ok(o_crc_ok),
		.o_result_valid(o_result_valid), .o_rh_centi(o_rh_centi), .o_temp_centi(o_temp_centi),
		.o_data_valid(o_data_valid), .i_data_ready(i_data_ready), .o_data(o_data));

	ht_link_props ht_link_props_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
		.scl_o(ht_link_if_i.scl_o), .scl_oe(ht_link_if_i.scl_oe), .h_sda_o(ht_link_if_i.h_sda_o),
		.h_sda_oe(ht_link_if_i.h_sda_oe), .d_sda_o(ht_link_if_i.d_sda_o), .d_sda_oe(ht_link_if_i.d_sda_oe),
		.scl_i(ht_link_if_i.scl_i), .sda_i(ht_link_if_i.sda_i));

	always @(negedge i_ref_clk) begin
		if (o_conv_start === 1'b1) starts <= starts + 1;
		if (o_busy === 1'b1) busy_seen <= 1'b1;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		if (err_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	function automatic logic pick(input int sel);
		return (sel == 0) ? o_idle : o_result_valid;
	endfunction : pick

	task automatic wait_until(input int sel, input int lim);
		int n;
		n = 0;
		while (pick(sel) !== 1'b1) begin
			@(negedge i_ref_clk);
			n++;
			if (n > lim) begin
				err_count++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
				give_verdict();
			end
		end
	endtask : wait_until

	task automatic measure();
		i_measure = 1'b1;
		@(negedge i_ref_clk);
		i_measure = 1'b0;
	endtask : measure

	function automatic logic [7:0] crc_ref(input logic [47:0] d);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 47; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction : crc_ref

	// Compares the converted values and every byte that the read left in the buffer.
	task automatic check_read();
		logic [47:0] frame;
		frame = {8'h18, hum, tmp};
		check(o_rh_centi, 16'((longint'(hum) * 10000) >> 20));
		check(o_temp_centi, 16'(((longint'(tmp) * 20000) >> 20) - 5000));
		check({o_crc_ok, o_error}, {14'h0000, want_crc, 1'b0});
		got_q.delete();
		i_data_ready = 1'b1;
		repeat (40) begin
			if (o_data_valid === 1'b1) got_q.push_back(o_data);
			@(negedge i_ref_clk);
		end
		i_data_ready = 1'b0;
		check(o_data_valid, 16'h0000);
		check(16'(got_q.size()), want_crc ? 16'h0007 : 16'h0006);
		for (int k = 0; k < got_q.size() && k < 7; k++) begin
			check(got_q[k], (k < 6) ? frame[47 - 8 * k -: 8] : crc_ref(frame));
		end
	endtask : check_read

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(negedge i_ref_clk);
		i_reset_n = 1'b1;
		repeat (500) @(negedge i_ref_clk);
		check({o_ready, o_idle}, 16'h0000);
		wait_until(0, 20000);
		check(o_ready, 16'h0001);
		check({o_calibrated, o_cal_ok, o_error}, 16'h0006);
		measure();
		wait_until(1, 40000);
		check_read();
		check({starts[1:0], busy_seen, o_busy}, 16'h0006);
		// An uncalibrated sensor needs the register writes; the next read skips the check byte.
		i_reset_n = 1'b0;
		factory_cal = 1'b0;
		want_crc = 1'b0;
		hum = 20'hFEDCB;
		tmp = 20'h01234;
		repeat (5) @(negedge i_ref_clk);
		i_reset_n = 1'b1;
		wait_until(0, 40000);
		check({o_calibrated, o_cal_ok, o_error}, 16'h0004);
		measure();
		wait_until(1, 40000);
		check_read();
		check({starts[1:0], o_cal_ok, o_busy}, 16'h0008);
		give_verdict();
	end
endmodule : humidity_temp_i2c_readout_bench

/* pkg/ht_defines.svh */
// Shared constants for the humidity and temperature sensor link.
`ifndef HT_DEFINES_SVH
`define HT_DEFINES_SVH

`define HT_ADDR 7'h38
`define HT_CMD_STATUS 8'h71
`define HT_CMD_TRIG 8'hAC
`define HT_TRIG_P0 8'h30
`define HT_TRIG_P1 8'h00
`define HT_INIT_R0 8'h1B
`define HT_INIT_R1 8'h1C
`define HT_INIT_R2 8'h1E
`define HT_INIT_FILL 8'h00
`define HT_CAL_MASK 8'h18
`define HT_ST_BUSY 7
`define HT_ST_CAL 3
`define HT_ST_CAL_MIRROR 4
`define HT_CRC_INIT 8'hFF
`define HT_CRC_POLY 8'h31
`define HT_IDLE_BYTE 8'hFF

`define HT_CLK_HZ 100000000
`define HT_CYC_PER_MS (`HT_CLK_HZ / 1000)
`define HT_PWR_MIN_MS 100
`define HT_PWR_MAX_MS 500
`define HT_GAP_MS 10
`define HT_CONV_WAIT_MS 250
`define HT_POLL_MS 10
`define HT_DEV_CONV_MS 80
`define HT_SCL_HZ 100000
`define HT_QUARTER_CYC (`HT_CLK_HZ / (`HT_SCL_HZ * 4))

`endif

/* pkg/ht_link_if.sv */
// Two-wire link between host and sensor, with open-drain resolution of both lines.
interface ht_link_if;
	logic scl_o;
	logic scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl_i;
	logic sda_i;

	// Pull-ups hold a line high unless a driver pulls it low.
	assign scl_i = !(scl_oe && !scl_o);
	assign sda_i = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

	modport host (output scl_o, output scl_oe, output h_sda_o, output h_sda_oe, input scl_i, input sda_i);
	modport dev (output d_sda_o, output d_sda_oe, input scl_i, input sda_i);
endinterface : ht_link_if

/* pkg/ht_pkg.sv */
// Types and the check-byte function shared by both ends of the sensor link.
`include "ht_defines.svh"

package ht_pkg;

	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_ADDR = 3'h1,
		D_ADDR_ACK = 3'h3,
		D_RX = 3'h2,
		D_RX_ACK = 3'h6,
		D_TX = 3'h7,
		D_TX_ACK = 3'h5
	} dev_state_t;

	typedef enum logic [3:0] {
		S_POWER = 4'h0,
		S_CHKCMD = 4'h1,
		S_CHKRD = 4'h3,
		S_INIT = 4'h2,
		S_IDLE = 4'h6,
		S_GAP = 4'h7,
		S_TRIG = 4'h5,
		S_CONV = 4'h4,
		S_READ = 4'hC
	} host_state_t;

	typedef enum logic [1:0] {
		P_IDLE = 2'h0,
		P_START = 2'h1,
		P_BYTE = 2'h3,
		P_STOP = 2'h2
	} phase_t;

	// Check byte over status and both raw values, most significant bit first.
	function automatic logic [7:0] crc8(input logic [47:0] d);
		logic [7:0] c;
		c = `HT_CRC_INIT;
		for (int i = 47; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ `HT_CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8

endpackage : ht_pkg

/* rtl/ht_host.sv */
// Host end of the link: start-up check, triggered measurement, polling, result read and conversion.
`include "ht_defines.svh"

module ht_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;

	assign o_ready = (cnt_q < (AW + 1)'(DEPTH));
	assign o_valid = (cnt_q != '0);
	assign o_data = mem_q[rd_q];

	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_data;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
			rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
			cnt_q <= (AW + 1)'(cnt_q + push - pop);
		end
	end
endmodule : ht_fifo

module ht_host #(
	parameter int unsigned PWR_CYCLES = `HT_PWR_MAX_MS * `HT_CYC_PER_MS,
	parameter int unsigned GAP_CYCLES = `HT_GAP_MS * `HT_CYC_PER_MS,
	parameter int unsigned CONV_CYCLES = `HT_CONV_WAIT_MS * `HT_CYC_PER_MS,
	parameter int unsigned POLL_CYCLES = `HT_POLL_MS * `HT_CYC_PER_MS,
	parameter int unsigned QUARTER_CYCLES = `HT_QUARTER_CYC,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	ht_link_if.host link,
	input wire logic i_measure,
	input wire logic i_want_crc,
	output logic o_idle,
	output logic o_cal_ok,
	output logic o_error,
	output logic o_crc_ok,
	output logic o_result_valid,
	output logic [13:0] o_rh_centi,
	output logic signed [15:0] o_temp_centi,
	output logic o_data_valid,
	input wire logic i_data_ready,
	output logic [7:0] o_data
);
	localparam logic [8:0] QUARTER = 9'(QUARTER_CYCLES);
	localparam ht_pkg::host_state_t S_POWER = ht_pkg::S_POWER;
	localparam ht_pkg::host_state_t S_CHKCMD = ht_pkg::S_CHKCMD;
	localparam ht_pkg::host_state_t S_CHKRD = ht_pkg::S_CHKRD;
	localparam ht_pkg::host_state_t S_INIT = ht_pkg::S_INIT;
	localparam ht_pkg::host_state_t S_IDLE = ht_pkg::S_IDLE;
	localparam ht_pkg::host_state_t S_GAP = ht_pkg::S_GAP;
	localparam ht_pkg::host_state_t S_TRIG = ht_pkg::S_TRIG;
	localparam ht_pkg::host_state_t S_CONV = ht_pkg::S_CONV;
	localparam ht_pkg::host_state_t S_READ = ht_pkg::S_READ;
	localparam ht_pkg::phase_t P_IDLE = ht_pkg::P_IDLE;
	localparam ht_pkg::phase_t P_START = ht_pkg::P_START;
	localparam ht_pkg::phase_t P_BYTE = ht_pkg::P_BYTE;
	localparam ht_pkg::phase_t P_STOP = ht_pkg::P_STOP;

	// ------------------------------------------------------------
	// Pin synchroniser, bit-rate divider and state
	// ------------------------------------------------------------
	logic sda_m, sda_s;
	ht_pkg::host_state_t st_q;
	ht_pkg::phase_t ph_q;
	logic [8:0] div_q;
	logic tick_q, scl_oe_q, sda_oe_q, nack_q, err_q, cal_ok_q, crc_ok_q, res_valid_q, idle_q;
	logic [1:0] q_q, k_q;
	logic [3:0] bc_q;
	logic [2:0] bi_q;
	logic [7:0] sh_q, stat_q, crc_rx_q;
	logic [31:0] cnt_q;
	logic [47:0] res_q;
	logic [13:0] rh_q;
	logic signed [15:0] temp_q;

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			{sda_m, sda_s} <= 2'h3;
			div_q <= 9'h000;
			tick_q <= 1'b0;
			idle_q <= 1'b0;
		end else begin
			{sda_m, sda_s} <= {link.sda_i, sda_m};
			div_q <= (div_q == QUARTER - 9'h001) ? 9'h000 : div_q + 9'h001;
			tick_q <= (div_q == QUARTER - 9'h001);
			idle_q <= (st_q == S_IDLE) && (ph_q == P_IDLE);
		end
	end

	// ------------------------------------------------------------
	// Byte selection and decode
	// ------------------------------------------------------------
	wire rd_xfer = (st_q == S_CHKRD) || (st_q == S_READ);
	wire wr_byte = (bi_q == 3'h0) || !rd_xfer;
	wire cur_busy = (bi_q == 3'h1) ? sh_q[`HT_ST_BUSY] : stat_q[`HT_ST_BUSY];
	wire [2:0] last_idx = (st_q == S_READ) ? (cur_busy ? 3'h1 : (i_want_crc ? 3'h7 : 3'h6))
		: (st_q == S_CHKCMD || st_q == S_CHKRD) ? 3'h1 : 3'h3;
	wire at_ack = (bc_q == 4'h8);
	wire push_req = tick_q && ph_q == P_BYTE && q_q == 2'h0 && at_ack && st_q == S_READ && !wr_byte
		&& !(bi_q == 3'h1 && sh_q[`HT_ST_BUSY]);
	wire fifo_ready;
	wire stall = push_req && !fifo_ready;
	wire step = tick_q && !stall;
	wire cal_ok_w = ((stat_q & `HT_CAL_MASK) == `HT_CAL_MASK);
	wire [33:0] rh_prod = {14'h0000, res_q[39:20]} * 34'h0_0000_2710;
	wire [34:0] temp_prod = {15'h0000, res_q[19:0]} * 35'h0_0000_4E20;

	// Byte to send at a given index of the current write transfer.
	function automatic logic [7:0] wbyte(input ht_pkg::host_state_t s, input logic [1:0] k,
		input logic [2:0] bi, input logic rd);
		logic [7:0] b;
		b = `HT_INIT_FILL;
		if (bi == 3'h0) begin
			b = {`HT_ADDR, rd};
		end else if (s == S_CHKCMD) begin
			b = `HT_CMD_STATUS;
		end else if (s == S_INIT && bi == 3'h1) begin
			b = (k == 2'h0) ? `HT_INIT_R0 : (k == 2'h1) ? `HT_INIT_R1 : `HT_INIT_R2;
		end else if (s == S_TRIG) begin
			b = (bi == 3'h1) ? `HT_CMD_TRIG : (bi == 3'h2) ? `HT_TRIG_P0 : `HT_TRIG_P1;
		end
		return b;
	endfunction : wbyte

	// ------------------------------------------------------------
	// Bit engine and sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			st_q <= S_POWER;
			ph_q <= P_IDLE;
			cnt_q <= PWR_CYCLES;
			q_q <= 2'h0;
			k_q <= 2'h0;
			bc_q <= 4'h0;
			bi_q <= 3'h0;
			sh_q <= 8'h00;
			stat_q <= 8'h00;
			crc_rx_q <= 8'h00;
			res_q <= 48'h0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			nack_q <= 1'b0;
			err_q <= 1'b0;
			cal_ok_q <= 1'b0;
			crc_ok_q <= 1'b0;
			res_valid_q <= 1'b0;
			rh_q <= 14'h0000;
			temp_q <= 16'sh0000;
		end else begin
			res_valid_q <= 1'b0;
			if (cnt_q != 32'h0) begin
				cnt_q <= cnt_q - 32'h1;
			end
			if (step && ph_q != P_IDLE) begin
				q_q <= q_q + 2'h1;
				unique case (ph_q)
					P_START: begin
						if (q_q == 2'h1) begin
							sda_oe_q <= 1'b1;
						end else if (q_q == 2'h2) begin
							scl_oe_q <= 1'b1;
							ph_q <= P_BYTE;
							q_q <= 2'h0;
							bc_q <= 4'h0;
							bi_q <= 3'h0;
							sh_q <= wbyte(st_q, k_q, 3'h0, rd_xfer);
						end
					end
					P_BYTE: begin
						if (q_q == 2'h0) begin
							scl_oe_q <= 1'b1;
							sda_oe_q <= at_ack ? (!wr_byte && bi_q != last_idx) : (wr_byte && !sh_q[7]);
						end else if (q_q == 2'h1) begin
							scl_oe_q <= 1'b0;
						end else if (q_q == 2'h2) begin
							if (at_ack) begin
								nack_q <= sda_s;
							end else if (!wr_byte) begin
								sh_q <= {sh_q[6:0], sda_s};
							end
						end else begin
							scl_oe_q <= 1'b1;
							if (!at_ack) begin
								bc_q <= bc_q + 4'h1;
								sh_q <= wr_byte ? {sh_q[6:0], 1'b0} : sh_q;
							end else begin
								if (!wr_byte && bi_q == 3'h1) begin
									stat_q <= sh_q;
								end
								if (!wr_byte && st_q == S_READ && bi_q <= 3'h6) begin
									res_q <= {res_q[39:0], sh_q};
								end
								if (!wr_byte && bi_q == 3'h7) begin
									crc_rx_q <= sh_q;
								end
								if ((wr_byte && nack_q) || bi_q == last_idx) begin
									err_q <= err_q || (wr_byte && nack_q);
									ph_q <= P_STOP;
								end else begin
									bi_q <= bi_q + 3'h1;
									bc_q <= 4'h0;
									sh_q <= wbyte(st_q, k_q, bi_q + 3'h1, rd_xfer);
								end
							end
						end
					end
					P_STOP: begin
						if (q_q == 2'h0) begin
							sda_oe_q <= 1'b1;
						end else if (q_q == 2'h1) begin
							scl_oe_q <= 1'b0;
						end else if (q_q == 2'h2) begin
							sda_oe_q <= 1'b0;
						end else begin
							ph_q <= P_IDLE;
						end
					end
					P_IDLE: begin
						q_q <= 2'h0;
					end
				endcase
			end else if (ph_q == P_IDLE) begin
				q_q <= 2'h0;
				unique case (st_q)
					S_POWER: begin
						if (cnt_q == 32'h0) begin
							st_q <= S_CHKCMD;
							ph_q <= P_START;
						end
					end
					S_CHKCMD: begin
						st_q <= err_q ? S_IDLE : S_CHKRD;
						ph_q <= err_q ? P_IDLE : P_START;
					end
					S_CHKRD: begin
						cal_ok_q <= cal_ok_w;
						k_q <= 2'h0;
						st_q <= cal_ok_w ? S_IDLE : S_INIT;
						ph_q <= cal_ok_w ? P_IDLE : P_START;
					end
					S_INIT: begin
						k_q <= k_q + 2'h1;
						st_q <= (k_q == 2'h2 || err_q) ? S_IDLE : S_INIT;
						ph_q <= (k_q == 2'h2 || err_q) ? P_IDLE : P_START;
					end
					S_IDLE: begin
						if (i_measure) begin
							err_q <= 1'b0;
							st_q <= S_GAP;
							cnt_q <= GAP_CYCLES;
						end
					end
					S_GAP: begin
						if (cnt_q == 32'h0) begin
							st_q <= S_TRIG;
							ph_q <= P_START;
						end
					end
					S_TRIG: begin
						st_q <= err_q ? S_IDLE : S_CONV;
						cnt_q <= CONV_CYCLES;
					end
					S_CONV: begin
						if (cnt_q == 32'h0) begin
							st_q <= S_READ;
							ph_q <= P_START;
						end
					end
					S_READ: begin
						if (stat_q[`HT_ST_BUSY] && !err_q) begin
							st_q <= S_CONV;
							cnt_q <= POLL_CYCLES;
						end else begin
							st_q <= S_IDLE;
							res_valid_q <= !err_q;
							crc_ok_q <= i_want_crc && (ht_pkg::crc8(res_q) == crc_rx_q);
							rh_q <= rh_prod[33:20];
							temp_q <= $signed({1'b0, temp_prod[34:20]}) - 16'sh1388;
						end
					end
					default: begin
						st_q <= S_IDLE;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Result buffer
	// ------------------------------------------------------------
	ht_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_valid(push_req),
		.o_ready(fifo_ready),
		.i_data(sh_q),
		.o_valid(o_data_valid),
		.i_ready(i_data_ready),
		.o_data(o_data)
	);

	assign link.scl_o = 1'b0;
	assign link.scl_oe = scl_oe_q;
	assign link.h_sda_o = 1'b0;
	assign link.h_sda_oe = sda_oe_q;
	assign o_idle = idle_q;
	assign o_cal_ok = cal_ok_q;
	assign o_error = err_q;
	assign o_crc_ok = crc_ok_q;
	assign o_result_valid = res_valid_q;
	assign o_rh_centi = rh_q;
	assign o_temp_centi = temp_q;

endmodule : ht_host

/* rtl/ht_sensor_dev.sv */
// Sensor end of the link: bus target, status, triggered conversion and result read.
`include "ht_defines.svh"

module ht_sensor_dev #(
	parameter int unsigned PWR_CYCLES = `HT_PWR_MIN_MS * `HT_CYC_PER_MS,
	parameter int unsigned CONV_CYCLES = `HT_DEV_CONV_MS * `HT_CYC_PER_MS
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	ht_link_if.dev link,
	input wire logic [19:0] i_humidity_raw,
	input wire logic [19:0] i_temperature_raw,
	input wire logic i_factory_cal,
	output logic o_ready,
	output logic o_busy,
	output logic o_calibrated,
	output logic o_conv_start
);

	// ------------------------------------------------------------
	// Pin synchronisers and bus conditions
	// ------------------------------------------------------------
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			{scl_m, scl_s, scl_p} <= 3'h7;
			{sda_m, sda_s, sda_p} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_p} <= {link.scl_i, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {link.sda_i, sda_m, sda_s};
		end
	end

	wire scl_rise = scl_s && !scl_p;
	wire scl_fall = !scl_s && scl_p;
	wire start_c = scl_s && scl_p && sda_p && !sda_s;
	wire stop_c = scl_s && scl_p && !sda_p && sda_s;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ht_pkg::dev_state_t st_q;
	localparam ht_pkg::dev_state_t D_IDLE = ht_pkg::D_IDLE;
	localparam ht_pkg::dev_state_t D_ADDR = ht_pkg::D_ADDR;
	localparam ht_pkg::dev_state_t D_ADDR_ACK = ht_pkg::D_ADDR_ACK;
	localparam ht_pkg::dev_state_t D_RX = ht_pkg::D_RX;
	localparam ht_pkg::dev_state_t D_RX_ACK = ht_pkg::D_RX_ACK;
	localparam ht_pkg::dev_state_t D_TX = ht_pkg::D_TX;
	localparam ht_pkg::dev_state_t D_TX_ACK = ht_pkg::D_TX_ACK;
	logic [31:0] pwr_cnt_q, conv_cnt_q;
	logic ready_q, busy_q, cal_q, conv_start_q, got_q, rw_q, p0_ok_q;
	logic [2:0] bit_q, rd_idx_q, init_q;
	logic [1:0] wr_idx_q;
	logic [7:0] sh_q, cmd_q;
	logic [19:0] hum_q, temp_q;
	logic sda_oe_q;

	// Status layout: busy on top, calibration flag and its mirror.
	wire [7:0] status_w = {busy_q, 2'b00, cal_q, cal_q, 3'b000};
	wire [47:0] result_w = {status_w, hum_q, temp_q};
	wire [7:0] crc_w = ht_pkg::crc8(result_w);
	wire byte_done = scl_fall && got_q;
	wire addr_hit = (sh_q[7:1] == `HT_ADDR);
	wire trig_ok = (cmd_q == `HT_CMD_TRIG) && p0_ok_q && (sh_q == `HT_TRIG_P1) && !busy_q;

	// Byte offered at a given read index; after the check byte the line idles high.
	function automatic logic [7:0] tx_byte(input logic [2:0] idx, input logic [47:0] r, input logic [7:0] c);
		logic [7:0] b;
		b = `HT_IDLE_BYTE;
		if (idx <= 3'h5) begin
			b = r[47 - 8 * idx -: 8];
		end else if (idx == 3'h6) begin
			b = c;
		end
		return b;
	endfunction : tx_byte

	wire [7:0] next_tx = tx_byte(rd_idx_q, result_w, crc_w);

	// ------------------------------------------------------------
	// Power-up readiness, calibration and conversion
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			pwr_cnt_q <= 32'h0;
			ready_q <= 1'b0;
		end else if (!ready_q) begin
			pwr_cnt_q <= scl_s ? pwr_cnt_q + 32'h1 : 32'h0;
			ready_q <= scl_s && (pwr_cnt_q >= PWR_CYCLES - 1);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			busy_q <= 1'b0;
			cal_q <= 1'b0;
			conv_cnt_q <= 32'h0;
			conv_start_q <= 1'b0;
			hum_q <= 20'h0;
			temp_q <= 20'h0;
		end else begin
			cal_q <= cal_q || i_factory_cal || (&init_q);
			conv_start_q <= 1'b0;
			if (st_q == D_RX && byte_done && wr_idx_q == 2'h2 && trig_ok) begin
				busy_q <= 1'b1;
				conv_start_q <= 1'b1;
				conv_cnt_q <= CONV_CYCLES;
			end else if (busy_q) begin
				conv_cnt_q <= conv_cnt_q - 32'h1;
				if (conv_cnt_q == 32'h1) begin
					hum_q <= i_humidity_raw;
					temp_q <= i_temperature_raw;
					busy_q <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Bus target
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			st_q <= D_IDLE;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			got_q <= 1'b0;
			rw_q <= 1'b0;
			wr_idx_q <= 2'h0;
			rd_idx_q <= 3'h0;
			cmd_q <= 8'h00;
			p0_ok_q <= 1'b0;
			init_q <= 3'h0;
			sda_oe_q <= 1'b0;
		end else if (start_c && ready_q) begin
			st_q <= D_ADDR;
			bit_q <= 3'h0;
			got_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (stop_c) begin
			st_q <= D_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			unique case (st_q)
				D_IDLE: begin
					sda_oe_q <= 1'b0;
				end
				D_ADDR, D_RX: begin
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_s};
						bit_q <= bit_q + 3'h1;
						got_q <= (bit_q == 3'h7);
					end else if (byte_done) begin
						got_q <= 1'b0;
						sda_oe_q <= (st_q == D_RX) || addr_hit;
						if (st_q == D_ADDR) begin
							st_q <= addr_hit ? D_ADDR_ACK : D_IDLE;
							rw_q <= sh_q[0];
						end else begin
							st_q <= D_RX_ACK;
							if (wr_idx_q != 2'h3) begin
								wr_idx_q <= wr_idx_q + 2'h1;
							end
							if (wr_idx_q == 2'h0) begin
								cmd_q <= sh_q;
								init_q <= init_q | {sh_q == `HT_INIT_R2, sh_q == `HT_INIT_R1, sh_q == `HT_INIT_R0};
							end
							if (wr_idx_q == 2'h1) begin
								p0_ok_q <= (sh_q == `HT_TRIG_P0);
							end
						end
					end
				end
				D_ADDR_ACK: begin
					if (scl_fall) begin
						bit_q <= 3'h0;
						wr_idx_q <= 2'h0;
						if (rw_q) begin
							st_q <= D_TX;
							rd_idx_q <= 3'h1;
							sh_q <= tx_byte(3'h0, result_w, crc_w);
							sda_oe_q <= !status_w[7];
						end else begin
							st_q <= D_RX;
							sda_oe_q <= 1'b0;
						end
					end
				end
				D_RX_ACK: begin
					if (scl_fall) begin
						st_q <= D_RX;
						sda_oe_q <= 1'b0;
					end
				end
				D_TX: begin
					if (scl_fall) begin
						if (bit_q == 3'h7) begin
							st_q <= D_TX_ACK;
							sda_oe_q <= 1'b0;
						end else begin
							sda_oe_q <= !sh_q[6];
							sh_q <= {sh_q[6:0], 1'b0};
							bit_q <= bit_q + 3'h1;
						end
					end
				end
				D_TX_ACK: begin
					if (scl_rise) begin
						got_q <= !sda_s;
						if (sda_s) begin
							st_q <= D_IDLE;
						end
					end else if (scl_fall && got_q) begin
						got_q <= 1'b0;
						st_q <= D_TX;
						bit_q <= 3'h0;
						sh_q <= next_tx;
						sda_oe_q <= !next_tx[7];
						rd_idx_q <= rd_idx_q + 3'h1;
					end
				end
				default: begin
					st_q <= D_IDLE;
				end
			endcase
		end
	end

	assign link.d_sda_o = 1'b0;
	assign link.d_sda_oe = sda_oe_q;
	assign o_ready = ready_q;
	assign o_busy = busy_q;
	assign o_calibrated = cal_q;
	assign o_conv_start = conv_start_q;

endmodule : ht_sensor_dev
